// [src/twsrs_top.sv]
// Slave receiver status and next-action logic for a two-wire bus.
// Assumes link_clk_i runs freely and oversamples the bus lines;
// control inputs come from software logic on mclk_i.
`timescale 1ns/1ps
module twsrs_top #(
  parameter int FIFO_DEPTH = twsrs_pkg::FIFO_DEPTH
) (
  input wire logic mclk_i, // System clock
  input wire logic srst_i, // Sync reset, high
  input wire logic link_clk_i, // Bus sample clock
  input wire logic scl_i, // Serial clock level
  output logic scl_oe_n_o, // Low pulls clock low
  input wire logic sda_i, // Serial data level
  output logic sda_oe_n_o, // Low pulls data low
  input wire logic [6:0] own_slave_addr_i, // Own address
  input wire logic general_call_enable_i, // Answer call
  input wire logic ack_enable_i, // Acknowledge enable
  input wire logic start_request_i, // Start wanted
  input wire logic flag_clear_i, // Clear service flag
  input wire logic arb_lost_i, // Master lost arbitration
  output logic start_issue_o, // Pulse: send START
  output logic service_flag_o, // Software must act
  output logic [7:0] status_reg_o, // Status code
  output logic [7:0] byte_reg_o, // Last received byte
  output logic [7:0] rx_data_o, // Stream byte
  output logic rx_valid_o, // Stream byte valid
  input wire logic rx_ready_i // Stream byte taken
);
  // Link domain state
  typedef struct packed {
    logic rst_m, rst_s;
    logic scl_m, scl_s, scl_d;
    logic sda_m, sda_s, sda_d;
    logic rel_m, rel_s, ack_m, ack_s, gce_m, gce_s;
    logic [6:0] adr_m, adr_s;
    twsrs_pkg::twsrs_lk_t st;
    logic [7:0] sh;
    logic [3:0] cnt;
    twsrs_pkg::twsrs_ev_t kind;
    logic [7:0] ev_byte;
    logic ev_ack, req, seen, sda_oe_n, scl_oe_n, adrsd, busy;
  } twsrs_link_t;
  // System domain state
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] byte_reg;
    twsrs_pkg::twsrs_md_t mode;
    logic flag, req_m, req_s, seen, rel, ack_q, gce_q;
    logic [6:0] adr;
    logic busy_m, busy_s, lpend, pend, go, push_v, rx_v;
    logic [7:0] push_d;
    logic [7:0] rx_d;
  } twsrs_sys_t;
  twsrs_link_t l, next_l;
  twsrs_sys_t s, next_s;
  logic l_start; // START seen
  logic l_stop; // STOP seen
  logic l_rise; // Clock rising
  logic l_fall; // Clock falling
  logic l_rel; // Release arrived
  logic l_own; // Own write address
  logic l_gc; // Enabled general call
  logic s_new; // Event waiting
  logic s_term; // Terminating status
  logic s_clr; // Flag cleared now
  logic s_acc; // Event taken now
  logic s_take; // Output slot free
  // Receive FIFO between status logic and stream port
  twsrs_fifo_if #(.W(twsrs_pkg::BYTE_W)) q ();
  twsrs_fifo #(.W(twsrs_pkg::BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .q(q)
  );
  assign q.push_valid = s.push_v;
  assign q.push_data = s.push_d;
  assign q.pop_ready = s_take;

  // Link side: sync inputs, detect conditions, shift bits
  always_comb begin
    next_l = l;
    next_l.rst_m = srst_i;
    next_l.rst_s = l.rst_m;
    next_l.scl_m = scl_i;
    next_l.scl_s = l.scl_m;
    next_l.scl_d = l.scl_s;
    next_l.sda_m = sda_i;
    next_l.sda_s = l.sda_m;
    next_l.sda_d = l.sda_s;
    next_l.rel_m = s.rel;
    next_l.rel_s = l.rel_m;
    next_l.ack_m = s.ack_q;
    next_l.ack_s = l.ack_m;
    next_l.gce_m = s.gce_q;
    next_l.gce_s = l.gce_m;
    next_l.adr_m = s.adr;
    next_l.adr_s = l.adr_m;
    l_start = l.sda_d & ~l.sda_s & l.scl_s & l.scl_d;
    l_stop = ~l.sda_d & l.sda_s & l.scl_s & l.scl_d;
    l_rise = ~l.scl_d & l.scl_s;
    l_fall = l.scl_d & ~l.scl_s;
    l_rel = l.rel_s != l.seen;
    l_own = (l.sh[7:1] == l.adr_s) & ~l.sh[0];
    l_gc = (l.sh == twsrs_pkg::GC_ADDR) & l.gce_s;
    if (l_start | l_stop) begin
      // Bus condition ends any addressed transfer
      if (l.adrsd) begin
        next_l.kind = twsrs_pkg::EV_END;
        next_l.req = ~l.req;
      end
      next_l.adrsd = 1'b0;
      next_l.sda_oe_n = 1'b1;
      next_l.cnt = 4'h0;
      next_l.busy = l_start;
      next_l.st = l_start ? twsrs_pkg::LK_ADDR : twsrs_pkg::LK_IDLE;
    end else begin
      unique case (l.st)
        twsrs_pkg::LK_IDLE: begin
          // Not addressed, watching only
          next_l.st = twsrs_pkg::LK_IDLE;
        end
        twsrs_pkg::LK_ADDR: begin
          if (l_rise) begin
            next_l.sh = {l.sh[6:0], l.sda_s};
            next_l.cnt = l.cnt + 4'h1;
          end else if (l_fall && l.cnt == twsrs_pkg::BITS_BYTE) begin
            // Answer only while acknowledge is enabled
            if (l.ack_s && (l_own || l_gc)) begin
              next_l.sda_oe_n = 1'b0;
              next_l.kind = l_own ? twsrs_pkg::EV_OWN
                                  : twsrs_pkg::EV_GC;
              next_l.ev_ack = 1'b1;
              next_l.st = twsrs_pkg::LK_ACK;
            end else begin
              next_l.st = twsrs_pkg::LK_IDLE;
            end
          end
        end
        twsrs_pkg::LK_ACK: begin
          // End of acknowledge bit: post event, hold clock
          if (l_fall) begin
            next_l.sda_oe_n = 1'b1;
            next_l.scl_oe_n = 1'b0;
            next_l.ev_byte = l.sh;
            next_l.req = ~l.req;
            next_l.adrsd = l.ev_ack;
            next_l.cnt = 4'h0;
            next_l.st = twsrs_pkg::LK_WAIT;
          end
        end
        twsrs_pkg::LK_WAIT: begin
          // Clock stays low until software clears the flag
          if (l_rel) begin
            next_l.seen = l.rel_s;
            next_l.scl_oe_n = 1'b1;
            next_l.st = l.adrsd ? twsrs_pkg::LK_DATA
                                : twsrs_pkg::LK_IDLE;
          end
        end
        twsrs_pkg::LK_DATA: begin
          if (l_rise) begin
            next_l.sh = {l.sh[6:0], l.sda_s};
            next_l.cnt = l.cnt + 4'h1;
          end else if (l_fall && l.cnt == twsrs_pkg::BITS_BYTE) begin
            // Live enable decides this acknowledge
            next_l.ev_ack = l.ack_s;
            next_l.sda_oe_n = ~l.ack_s;
            next_l.kind = twsrs_pkg::EV_DATA;
            next_l.st = twsrs_pkg::LK_ACK;
          end
        end
        default: begin
          next_l.st = twsrs_pkg::LK_IDLE;
        end
      endcase
    end
    if (l.rst_s) begin
      next_l.st = twsrs_pkg::LK_IDLE;
      next_l.cnt = 4'h0;
      next_l.req = 1'b0;
      next_l.seen = 1'b0;
      next_l.adrsd = 1'b0;
      next_l.busy = 1'b0;
      next_l.sda_oe_n = 1'b1;
      next_l.scl_oe_n = 1'b1;
      next_l.kind = twsrs_pkg::EV_OWN;
      next_l.ev_ack = 1'b0;
    end
  end

  // Link register
  always_ff @(posedge link_clk_i) begin
    l <= next_l;
  end
  // System side: status codes, flag and next action
  always_comb begin
    next_s = s;
    next_s.req_m = l.req;
    next_s.req_s = s.req_m;
    next_s.busy_m = l.busy;
    next_s.busy_s = s.busy_m;
    next_s.ack_q = ack_enable_i;
    next_s.gce_q = general_call_enable_i;
    next_s.adr = own_slave_addr_i;
    next_s.push_v = 1'b0;
    next_s.go = 1'b0;
    s_new = s.req_s != s.seen;
    s_term = (s.status == twsrs_pkg::ST_OWN_NACK) ||
             (s.status == twsrs_pkg::ST_GC_NACK) ||
             (s.status == twsrs_pkg::ST_STOP);
    s_clr = flag_clear_i & s.flag;
    s_acc = s_new & (~s.flag | flag_clear_i) &
            ((l.kind != twsrs_pkg::EV_DATA) |
             (q.push_ready & ~s.push_v));
    s_take = ~s.rx_v | rx_ready_i;
    // Software clears the flag and releases the link
    if (s_clr) begin
      next_s.flag = 1'b0;
      next_s.status = twsrs_pkg::ST_IDLE;
      if (s.lpend) begin
        next_s.rel = ~s.rel;
        next_s.lpend = 1'b0;
      end
      if (s_term && start_request_i) begin
        next_s.pend = 1'b1;
      end
    end
    // Pending START goes out once the bus is free
    if (s.pend && !s.busy_s) begin
      next_s.go = 1'b1;
      next_s.pend = 1'b0;
    end
    // New event wins over a clear in the same cycle
    if (s_acc) begin
      next_s.seen = s.req_s;
      next_s.flag = 1'b1;
      next_s.lpend = l.kind != twsrs_pkg::EV_END;
      unique case (l.kind)
        twsrs_pkg::EV_OWN: begin
          next_s.status = arb_lost_i ? twsrs_pkg::ST_ARB_OWN
                                     : twsrs_pkg::ST_OWN_W;
          next_s.mode = twsrs_pkg::MD_OWN;
        end
        twsrs_pkg::EV_GC: begin
          next_s.status = arb_lost_i ? twsrs_pkg::ST_ARB_GC
                                     : twsrs_pkg::ST_GC;
          next_s.mode = twsrs_pkg::MD_GC;
        end
        twsrs_pkg::EV_DATA: begin
          // Byte kept readable whatever the acknowledge
          next_s.byte_reg = l.ev_byte;
          next_s.push_v = 1'b1;
          next_s.push_d = l.ev_byte;
          if (s.mode == twsrs_pkg::MD_GC) begin
            next_s.status = l.ev_ack ? twsrs_pkg::ST_GC_ACK
                                     : twsrs_pkg::ST_GC_NACK;
          end else begin
            next_s.status = l.ev_ack ? twsrs_pkg::ST_OWN_ACK
                                     : twsrs_pkg::ST_OWN_NACK;
          end
          if (!l.ev_ack) begin
            next_s.mode = twsrs_pkg::MD_NONE;
          end
        end
        twsrs_pkg::EV_END: begin
          next_s.status = twsrs_pkg::ST_STOP;
          next_s.mode = twsrs_pkg::MD_NONE;
        end
      endcase
    end
    // Output slot for the byte stream
    if (s_take) begin
      next_s.rx_v = q.pop_valid;
      if (q.pop_valid) begin
        next_s.rx_d = q.pop_data;
      end
    end
    if (srst_i) begin
      next_s.status = twsrs_pkg::ST_IDLE;
      next_s.flag = 1'b0;
      next_s.byte_reg = 8'h00;
      next_s.mode = twsrs_pkg::MD_NONE;
      next_s.seen = 1'b0;
      next_s.rel = 1'b0;
      next_s.ack_q = 1'b0;
      next_s.gce_q = 1'b0;
      next_s.lpend = 1'b0;
      next_s.pend = 1'b0;
      next_s.go = 1'b0;
      next_s.push_v = 1'b0;
      next_s.rx_v = 1'b0;
      next_s.rx_d = 8'h00;
    end
  end

  // System register
  always_ff @(posedge mclk_i) begin
    s <= next_s;
  end
  // Outputs straight from flops
  assign scl_oe_n_o = l.scl_oe_n;
  assign sda_oe_n_o = l.sda_oe_n;
  assign start_issue_o = s.go;
  assign service_flag_o = s.flag;
  assign status_reg_o = s.status;
  assign byte_reg_o = s.byte_reg;
  assign rx_data_o = s.rx_d;
  assign rx_valid_o = s.rx_v;

  // Checks on the system side, and on the link side on link_clk_i
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (srst_i);
  own_nack_a: assert property (s_acc && l.kind == twsrs_pkg::EV_DATA &&
    !l.ev_ack && s.mode == twsrs_pkg::MD_OWN |=> s.flag &&
    s.status == twsrs_pkg::ST_OWN_NACK && s.byte_reg == $past(l.ev_byte))
    else $error("own data nack status wrong");
  gc_ack_a: assert property (s_acc && l.kind == twsrs_pkg::EV_DATA &&
    l.ev_ack && s.mode == twsrs_pkg::MD_GC |=>
    s.status == twsrs_pkg::ST_GC_ACK ##1 s.mode == twsrs_pkg::MD_GC)
    else $error("general call ack status wrong");
  gc_nack_a: assert property (s_acc && l.kind == twsrs_pkg::EV_DATA &&
    !l.ev_ack && s.mode == twsrs_pkg::MD_GC |=>
    s.status == twsrs_pkg::ST_GC_NACK && s.push_v)
    else $error("general call nack status wrong");
  stop_code_a: assert property (s_acc && l.kind == twsrs_pkg::EV_END
    |=> s.status == twsrs_pkg::ST_STOP && s.flag && !s.lpend)
    else $error("stop status wrong");
  unaddr_a: assert property (s_clr && s_term && !s_acc |=>
    s.mode == twsrs_pkg::MD_NONE && !s.flag && !s.lpend)
    else $error("not unaddressed after end");
  start_req_a: assert property (s_clr && s_term && start_request_i
    |=> s.pend || s.go ##[1:40] s.go)
    else $error("start not issued");
  own_w_a: assert property (s_acc && l.kind == twsrs_pkg::EV_OWN &&
    !arb_lost_i |=> s.status == twsrs_pkg::ST_OWN_W && s.flag)
    else $error("own address status wrong");
  arb_gc_a: assert property (s_acc && l.kind == twsrs_pkg::EV_GC &&
    arb_lost_i |=> s.status == twsrs_pkg::ST_ARB_GC)
    else $error("lost arbitration call status wrong");
  hold_low_a: assert property (@(posedge link_clk_i) disable iff
    (l.rst_s) l.st == twsrs_pkg::LK_WAIT && !l_rel |=> !l.scl_oe_n)
    else $error("clock not held while waiting");
  nack_next_a: assert property (@(posedge link_clk_i) disable iff
    (l.rst_s) l.st == twsrs_pkg::LK_DATA && !l_start && !l_stop &&
    l_fall && l.cnt == twsrs_pkg::BITS_BYTE && !l.ack_s
    |=> l.sda_oe_n && l.st == twsrs_pkg::LK_ACK)
    else $error("byte acknowledged with enable off");
  gc_gate_a: assert property (@(posedge link_clk_i) disable iff
    (l.rst_s) l.st == twsrs_pkg::LK_ADDR && !l_start && !l_stop &&
    l_fall && l.cnt == twsrs_pkg::BITS_BYTE && !l_own && !l.gce_s
    |=> l.sda_oe_n)
    else $error("call answered while disabled");
  data_ack_c: cover property (s.flag && s.status == twsrs_pkg::ST_OWN_ACK);
  gc_nack_c: cover property (s.flag && s.status == twsrs_pkg::ST_GC_NACK);
  stop_c: cover property (s.flag && s.status == twsrs_pkg::ST_STOP);
  start_c: cover property (s.go);
endmodule : twsrs_top

// [src/twsrs_pkg.sv]
// Constants for the two-wire slave receiver status block.
// Assumes one system clock and one free running link sample clock.
// Overview of operation
// - Own data NACKed posts 0x88, byte kept
// - General call data ACKed posts 0x90
// - General call data NACKed posts 0x98, byte kept
// - STOP or restart while addressed posts 0xA0
// - Terminal clear, ack off: ignore all addresses
// - Ack on: own address, gated general call
// - Start request: unaddressed, START when bus free
// - Own write address 0x60, data 0x80, end 0xA0
// - Lost arbitration then general call posts 0x78
// - Ack off mid transfer: NACK next byte
package twsrs_pkg;
  // Status codes, prescaler bits always zero
  localparam logic [7:0] ST_OWN_W = 8'h60;
  localparam logic [7:0] ST_ARB_OWN = 8'h68;
  localparam logic [7:0] ST_GC = 8'h70;
  localparam logic [7:0] ST_ARB_GC = 8'h78;
  localparam logic [7:0] ST_OWN_ACK = 8'h80;
  localparam logic [7:0] ST_OWN_NACK = 8'h88;
  localparam logic [7:0] ST_GC_ACK = 8'h90;
  localparam logic [7:0] ST_GC_NACK = 8'h98;
  localparam logic [7:0] ST_STOP = 8'hA0;
  localparam logic [7:0] ST_IDLE = 8'hF8;
  // General call address byte
  localparam logic [7:0] GC_ADDR = 8'h00;
  // Bits in one byte before the acknowledge bit
  localparam logic [3:0] BITS_BYTE = 4'h8;
  // Data path sizes
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 32;
  // Events passed from link to system side
  typedef enum logic [1:0] {
    EV_OWN = 2'b00,
    EV_GC = 2'b01,
    EV_DATA = 2'b10,
    EV_END = 2'b11
  } twsrs_ev_t;
  // Link side bit level states
  typedef enum logic [2:0] {
    LK_IDLE = 3'b000,
    LK_ADDR = 3'b001,
    LK_ACK = 3'b010,
    LK_WAIT = 3'b011,
    LK_DATA = 3'b100
  } twsrs_lk_t;
  // Addressing mode seen by software
  typedef enum logic [1:0] {
    MD_NONE = 2'b00,
    MD_OWN = 2'b01,
    MD_GC = 2'b10
  } twsrs_md_t;
endpackage : twsrs_pkg

// [src/twsrs_fifo_if.sv]
// Carrier between the status logic and its receive FIFO.
// Assumes both ends sit on the system clock.
`timescale 1ns/1ps
interface twsrs_fifo_if #(parameter int W = 8);
  logic push_valid; // Byte offered
  logic push_ready; // Room left
  logic [W-1:0] push_data; // Byte in
  logic pop_valid; // Byte waiting
  logic pop_ready; // Byte taken
  logic [W-1:0] pop_data; // Oldest byte
  modport src (output push_valid, push_data, pop_ready,
               input push_ready, pop_valid, pop_data);
  modport fifo (input push_valid, push_data, pop_ready,
                output push_ready, pop_valid, pop_data);
endinterface : twsrs_fifo_if

// [src/twsrs_fifo.sv]
// Flip-flop FIFO for received bytes.
// Assumes push and pop on the system clock, synchronous reset.
`timescale 1ns/1ps
module twsrs_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 32
) (
  input wire logic mclk_i, // System clock
  input wire logic srst_i, // Sync reset, high
  twsrs_fifo_if.fifo q // Push and pop sides
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  // Whole FIFO state
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [CW-1:0] cnt;
  } twsrs_fifo_st_t;
  twsrs_fifo_st_t f, next_f;
  logic do_push; // Write this cycle
  logic do_pop; // Read this cycle
  // Honest full and empty
  assign q.push_ready = f.cnt != CW'(DEPTH);
  assign q.pop_valid = f.cnt != '0;
  assign q.pop_data = f.mem[f.rd];
  // Next state
  always_comb begin
    next_f = f;
    do_push = q.push_valid & q.push_ready;
    do_pop = q.pop_ready & q.pop_valid;
    if (do_push) begin
      next_f.mem[f.wr] = q.push_data;
      next_f.wr = (f.wr == AW'(DEPTH - 1)) ? '0 : f.wr + AW'(1);
    end
    if (do_pop) begin
      next_f.rd = (f.rd == AW'(DEPTH - 1)) ? '0 : f.rd + AW'(1);
    end
    next_f.cnt = f.cnt + CW'(do_push) - CW'(do_pop);
    if (srst_i) begin
      next_f.wr = '0;
      next_f.rd = '0;
      next_f.cnt = '0;
    end
  end
  // State register
  always_ff @(posedge mclk_i) begin
    f <= next_f;
  end
endmodule : twsrs_fifo

// [verification/twsrs_bus_master.sv]
// Behavioural two-wire bus master for the slave receiver.
// Assumes open-drain wires resolved by the bench with pull-ups.
`timescale 1ns/1ps
module twsrs_bus_master (
  output logic scl_rel_o, // High releases clock
  output logic sda_rel_o, // High releases data
  input wire logic scl_i, // Resolved clock wire
  input wire logic sda_i // Resolved data wire
);
  localparam time HALF = 400; // Half bit, five link periods
  logic [7:0] acks[$]; // Acknowledge bits seen
  // Idle bus: both lines released
  initial begin
    scl_rel_o = 1'b1;
    sda_rel_o = 1'b1;
  end
  // Waits out stretching by the slave before timing the high phase
  task automatic scl_up();
    scl_rel_o = 1'b1;
    wait (scl_i === 1'b1);
  endtask : scl_up
  // One bit; data moves only while the clock is low
  task automatic bit_io(input logic b, output logic rd);
    #100;
    sda_rel_o = b;
    #(HALF - 100);
    scl_up();
    #(HALF / 2);
    rd = sda_i;
    #(HALF / 2);
    scl_rel_o = 1'b0;
  endtask : bit_io
  // Start or repeated start
  task automatic start();
    #100;
    sda_rel_o = 1'b1;
    #(HALF - 100);
    scl_up();
    #HALF;
    sda_rel_o = 1'b0;
    #HALF;
    scl_rel_o = 1'b0;
  endtask : start
  // Stop, leaving the bus free
  task automatic stop();
    #100;
    sda_rel_o = 1'b0;
    #(HALF - 100);
    scl_up();
    #HALF;
    sda_rel_o = 1'b1;
    #HALF;
  endtask : stop
  // Byte MSB first, then the acknowledge bit from the slave
  task automatic send(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    acks.push_back({7'h00, r});
  endtask : send
  // Address byte, n data bytes counting up from d0, then stop
  task automatic frame(input logic [7:0] a, input int n,
                       input logic [7:0] d0);
    start();
    send(a);
    for (int i = 0; i < n; i++) send(d0 + 8'(i));
    stop();
  endtask : frame
endmodule : twsrs_bus_master

// [verification/twsrs_bench.sv]
// Self-checking bench for the slave receiver status block.
// Assumes the design sources and the bus master model.
`timescale 1ns/1ps
module twsrs_bench;
  localparam logic [7:0] OWN_W = 8'h56; // Own address 0x2B, write
  logic mclk_i = 1'b0; // System clock
  logic srst_i = 1'b1; // Sync reset
  logic link_clk = 1'b0; // Bus sample clock
  logic scl_oe_n_o, sda_oe_n_o, m_scl, m_sda; // Line drivers
  logic general_call_enable_i = 1'b0; // Answer call
  logic ack_enable_i = 1'b1; // Acknowledge enable
  logic start_request_i = 1'b0; // Start wanted
  logic flag_clear_i = 1'b0; // Clear pulse
  logic arb_lost_i = 1'b0; // Lost arbitration
  logic rx_ready_i = 1'b1; // Stream taken
  logic start_issue_o, service_flag_o, rx_valid_o; // Flags
  logic [7:0] status_reg_o, byte_reg_o, rx_data_o; // Bytes out
  logic [7:0] st_q[$], by_q[$], rx_q[$]; // Logs
  logic ack_plan[$], sta_plan[$]; // Bits written at each clear
  int fails = 0; // Mismatches
  int comparisons = 0; // Compares made
  int starts = 0; // Start pulses seen
  wire scl_w = m_scl & scl_oe_n_o; // Pulled-up clock wire
  wire sda_w = m_sda & sda_oe_n_o; // Pulled-up data wire
  always #5 mclk_i = ~mclk_i;
  // Link clock, offset in phase
  initial begin
    #13;
    forever #40 link_clk = ~link_clk;
  end
  twsrs_top #(.FIFO_DEPTH(2)) dut (
    .mclk_i(mclk_i), .srst_i(srst_i), .link_clk_i(link_clk),
    .scl_i(scl_w), .scl_oe_n_o(scl_oe_n_o), .sda_i(sda_w),
    .sda_oe_n_o(sda_oe_n_o), .own_slave_addr_i(OWN_W[7:1]),
    .general_call_enable_i(general_call_enable_i),
    .ack_enable_i(ack_enable_i), .start_request_i(start_request_i),
    .flag_clear_i(flag_clear_i), .arb_lost_i(arb_lost_i),
    .start_issue_o(start_issue_o), .service_flag_o(service_flag_o),
    .status_reg_o(status_reg_o), .byte_reg_o(byte_reg_o),
    .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o),
    .rx_ready_i(rx_ready_i));
  twsrs_bus_master m (.scl_rel_o(m_scl), .sda_rel_o(m_sda),
    .scl_i(scl_w), .sda_i(sda_w));
  // Counts start pulses and collects the byte stream
  always @(posedge mclk_i) begin
    if (start_issue_o === 1'b1) starts <= starts + 1;
    if (rx_valid_o === 1'b1 && rx_ready_i) rx_q.push_back(rx_data_o);
  end
  // Compare one value
  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string n);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  // Compare a log against a list
  task automatic expect_q(input string n, input logic [7:0] got[$],
                          input logic [7:0] e[$]);
    check(8'(got.size()), 8'(e.size()), {n, " count"});
    foreach (e[i]) if (i < got.size()) check(got[i], e[i], n);
  endtask : expect_q
  // Software: logs status, checks the hold, clears the flag
  initial begin : software
    logic [7:0] s;
    forever begin
      @(posedge mclk_i);
      if (service_flag_o === 1'b1 && flag_clear_i === 1'b0) begin
        s = status_reg_o & 8'hF8;
        st_q.push_back(s);
        if (s[7] && s != 8'hA0) by_q.push_back(byte_reg_o);
        repeat (30) @(posedge mclk_i);
        if (s != 8'hA0) check(8'(scl_oe_n_o), 8'h00, "hold");
        if (ack_plan.size() > 0) ack_enable_i <= ack_plan.pop_front();
        if (sta_plan.size() > 0) start_request_i <= sta_plan.pop_front();
        flag_clear_i <= 1'b1;
        @(posedge mclk_i);
        flag_clear_i <= 1'b0;
        start_request_i <= 1'b0;
      end
    end
  end
  // One bus frame with fresh logs, then settle
  task automatic run(input logic [7:0] a, input int n,
                     input logic [7:0] d0);
    st_q.delete();
    by_q.delete();
    rx_q.delete();
    m.acks.delete();
    m.frame(a, n, d0);
    repeat (300) @(posedge mclk_i);
  endtask : run
  // Verdict and end of run
  task automatic final_report();
    if (fails == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  // Cuts a hang short
  initial begin : watchdog
    #900000;
    fails++;
    final_report();
  end
  // Test sequence
  initial begin
    repeat (40) @(posedge mclk_i);
    srst_i <= 1'b0;
    repeat (40) @(posedge mclk_i);
    // Own write, two acknowledged bytes
    run(OWN_W, 2, 8'hA5);
    expect_q("status", st_q, '{8'h60, 8'h80, 8'h80, 8'hA0});
    expect_q("ack", m.acks, '{8'h00, 8'h00, 8'h00});
    expect_q("byte", by_q, '{8'hA5, 8'hA6});
    expect_q("stream", rx_q, '{8'hA5, 8'hA6});
    // Ack cleared mid transfer, then ignored while off
    ack_plan = '{1'b1, 1'b0, 1'b0};
    run(OWN_W, 2, 8'h10);
    expect_q("status", st_q, '{8'h60, 8'h80, 8'h88});
    expect_q("ack", m.acks, '{8'h00, 8'h00, 8'h01});
    expect_q("byte", by_q, '{8'h10, 8'h11});
    run(OWN_W, 0, 8'h00);
    check(8'(st_q.size()), 8'h00, "ignored status");
    expect_q("ack", m.acks, '{8'h01});
    // General call, second byte refused
    @(posedge mclk_i);
    ack_enable_i <= 1'b1;
    general_call_enable_i <= 1'b1;
    ack_plan = '{1'b1, 1'b0, 1'b1};
    run(8'h00, 2, 8'h20);
    expect_q("status", st_q, '{8'h70, 8'h90, 8'h98});
    expect_q("ack", m.acks, '{8'h00, 8'h00, 8'h01});
    expect_q("byte", by_q, '{8'h20, 8'h21});
    expect_q("stream", rx_q, '{8'h20, 8'h21});
    run(OWN_W, 0, 8'h00);
    expect_q("status", st_q, '{8'h60, 8'hA0});
    @(posedge mclk_i);
    general_call_enable_i <= 1'b0;
    run(8'h00, 0, 8'h00);
    check(8'(st_q.size()), 8'h00, "call off status");
    expect_q("ack", m.acks, '{8'h01});
    // Lost arbitration, then addressed
    @(posedge mclk_i);
    general_call_enable_i <= 1'b1;
    arb_lost_i <= 1'b1;
    run(8'h00, 1, 8'h30);
    expect_q("status", st_q, '{8'h78, 8'h90, 8'hA0});
    run(OWN_W, 0, 8'h00);
    expect_q("status", st_q, '{8'h68, 8'hA0});
    @(posedge mclk_i);
    arb_lost_i <= 1'b0;
    // Start requested at the clear after a stop
    sta_plan = '{1'b0, 1'b1};
    run(OWN_W, 0, 8'h00);
    expect_q("status", st_q, '{8'h60, 8'hA0});
    check(8'(starts), 8'h01, "start pulses");
    // Stream stalled: buffer fills, the bus is held
    @(posedge mclk_i);
    rx_ready_i <= 1'b0;
    fork
      run(OWN_W, 4, 8'h50);
    join_none
    repeat (6000) @(posedge mclk_i);
    check(8'(st_q.size() < 5), 8'h01, "stall status");
    check(8'(scl_oe_n_o), 8'h00, "stall hold");
    rx_ready_i <= 1'b1;
    wait fork;
    expect_q("status", st_q,
      '{8'h60, 8'h80, 8'h80, 8'h80, 8'h80, 8'hA0});
    expect_q("stream", rx_q, '{8'h50, 8'h51, 8'h52, 8'h53});
    final_report();
  end
endmodule : twsrs_bench
